// ==== design/fepc_defs.svh ====
`ifndef FEPC_DEFS_SVH
`define FEPC_DEFS_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define FEPC_AW              10
`define FEPC_DW              32

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define FEPC_IDX_PAGE        8'hfc
`define FEPC_IDX_ROW         8'hfd
`define FEPC_IDX_COL         8'hfe
`define FEPC_IDX_PGCTL       8'hff
`define FEPC_IDX_PDATA       8'h40
`define FEPC_IDX_IRQ_STAT    8'h41
`define FEPC_IDX_IRQ_EN      8'h42
`define FEPC_IDX_IRQ_CLR     8'h43

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FEPC_INFO_BIT        7
`define FEPC_MASS_BIT        0
`define FEPC_PAGE_BIT        1
`define FEPC_ROW_BIT         2
`define FEPC_PAGE_RST        7'h00
`define FEPC_ROW_RST         3'h0
`define FEPC_COL_RST         7'h00
`define FEPC_COL_LAST        7'h7f
`define FEPC_EV_MASS         0
`define FEPC_EV_PAGE         1
`define FEPC_EV_ROW          2
`define FEPC_EV_TMO          3
`define FEPC_NEV             4
`define FEPC_RESP_OKAY       2'h0
`define FEPC_RESP_SLVERR     2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define FEPC_CLK_HZ          125000000
`define FEPC_MASS_ERASE_MS   200
`define FEPC_PAGE_ERASE_MS   10
`define FEPC_ROW_TMO_US      1000
`define FEPC_MASS_ERASE_CYC  (`FEPC_MASS_ERASE_MS * (`FEPC_CLK_HZ / 1000))
`define FEPC_PAGE_ERASE_CYC  (`FEPC_PAGE_ERASE_MS * (`FEPC_CLK_HZ / 1000))
`define FEPC_ROW_TMO_CYC     (`FEPC_ROW_TMO_US * (`FEPC_CLK_HZ / 1000000))

`endif

// ==== design/fepc_pkg.sv ====
package fepc_pkg;

  typedef enum logic [1:0] {
    FEPC_IDLE,
    FEPC_MASS,
    FEPC_PAGE,
    FEPC_ROW
  } fepc_state_type;

  typedef struct packed {
    logic       info;
    logic [6:0] page;
    logic [2:0] row;
    logic [6:0] col;
  } fepc_addr_type;

  typedef struct packed {
    logic [9:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } fepc_regwr_type;

endpackage : fepc_pkg

// ==== design/fepc_axil_slave.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fepc_defs.svh"

module fepc_axil_slave
  import fepc_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite
  input  wire logic [`FEPC_AW-1:0]  s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [`FEPC_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`FEPC_AW-1:0]  s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [`FEPC_DW-1:0]       s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Register side
  output logic                      wr_en,
  output fepc_regwr_type            wr_req,
  input  wire logic                 wr_err,
  output logic [`FEPC_AW-1:0]       rd_addr,
  input  wire logic [`FEPC_DW-1:0]  rd_data,
  input  wire logic                 rd_err
);

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs  = s_axi_wvalid & s_axi_wready;
  wire b_hs  = s_axi_bvalid & s_axi_bready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs  = s_axi_rvalid & s_axi_rready;

  // Address and data are held until both have arrived, in either order
  assign wr_en   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FEPC_RESP_OKAY;
      wr_req        <= '0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        wr_req.addr   <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wr_req.data  <= s_axi_wdata;
        wr_req.strb  <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `FEPC_RESP_SLVERR : `FEPC_RESP_OKAY;
      end
      if (b_hs) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FEPC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `FEPC_RESP_SLVERR : `FEPC_RESP_OKAY;
    end else if (r_hs) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : fepc_axil_slave
`default_nettype wire

// ==== design/fepc_flash_ctrl.sv ====
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "fepc_defs.svh"

module fepc_flash_ctrl
  import fepc_pkg::*;
#(
  parameter int unsigned MASS_ERASE_CYCLES = `FEPC_MASS_ERASE_CYC,
  parameter int unsigned PAGE_ERASE_CYCLES = `FEPC_PAGE_ERASE_CYC,
  parameter int unsigned ROW_TMO_CYCLES    = `FEPC_ROW_TMO_CYC
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite register bus
  input  wire logic [`FEPC_AW-1:0]  s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [`FEPC_DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [`FEPC_AW-1:0]  s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [`FEPC_DW-1:0]       s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // CPU access stall
  input  wire logic                 cpu_req,
  input  wire logic                 cpu_is_flash,
  input  wire logic                 cpu_is_write,
  output logic                      cpu_wait,
  // Flash array
  output logic                      arr_mass_erase,
  output logic                      arr_page_erase,
  output logic                      arr_row_mode,
  output fepc_addr_type             arr_addr,
  output logic                      arr_prog_strobe,
  output logic [7:0]                arr_prog_data,
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic                wr_en;
  fepc_regwr_type      wr_req;
  logic [`FEPC_AW-1:0] rd_addr;
  logic [`FEPC_DW-1:0] rd_data;
  logic                rd_err;
  logic                wr_err;

  fepc_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_req        (wr_req),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic                    info_page_select;
  logic [6:0]              page_sel;
  logic [2:0]              row_sel;
  logic [6:0]              col_sel;
  fepc_state_type          state;
  fepc_state_type          next_state;
  logic [31:0]             timer;
  logic [31:0]             next_timer;
  logic [`FEPC_NEV-1:0]    irq_status;
  logic [`FEPC_NEV-1:0]    irq_enable;
  logic [`FEPC_NEV-1:0]    events;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire [7:0] wr_idx  = wr_req.addr[9:2];
  wire       wr_lane = wr_en & wr_req.strb[0];
  wire       idle    = (state == FEPC_IDLE);
  wire       hit_page  = (wr_idx == `FEPC_IDX_PAGE);
  wire       hit_row   = (wr_idx == `FEPC_IDX_ROW);
  wire       hit_col   = (wr_idx == `FEPC_IDX_COL);
  wire       hit_pgctl = (wr_idx == `FEPC_IDX_PGCTL);
  wire       hit_pdata = (wr_idx == `FEPC_IDX_PDATA);
  wire       hit_ien   = (wr_idx == `FEPC_IDX_IRQ_EN);
  wire       hit_iclr  = (wr_idx == `FEPC_IDX_IRQ_CLR);
  wire       hit_istat = (wr_idx == `FEPC_IDX_IRQ_STAT);
  assign wr_err = wr_en & ~(hit_page | hit_row | hit_col | hit_pgctl | hit_pdata
                            | hit_ien | hit_iclr | hit_istat);

  // Address registers ignore writes while an operation runs; only a row program steps the column
  wire wr_page  = wr_lane & hit_page & idle;
  wire wr_row   = wr_lane & hit_row & idle;
  wire wr_col   = wr_lane & hit_col & idle;
  wire wr_pgctl = wr_lane & hit_pgctl & idle;
  wire wr_pdata = wr_lane & hit_pdata & (idle | state == FEPC_ROW);

  // Simultaneous command bits resolve mass over page over row
  wire start_mass = wr_pgctl & wr_req.data[`FEPC_MASS_BIT];
  wire start_page = wr_pgctl & ~start_mass & wr_req.data[`FEPC_PAGE_BIT];
  wire start_row  = wr_pgctl & ~start_mass & ~start_page
                    & wr_req.data[`FEPC_ROW_BIT];

  wire row_byte  = wr_pdata & (state == FEPC_ROW);
  wire row_last  = row_byte & (col_sel == `FEPC_COL_LAST);
  wire timer_end = (timer == 32'h0);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_timer = timer;
    events     = '0;
    case (state)
      FEPC_IDLE: begin
        if (start_mass) begin
          next_state = FEPC_MASS;
          next_timer = MASS_ERASE_CYCLES - 32'd1;
        end else if (start_page) begin
          next_state = FEPC_PAGE;
          next_timer = PAGE_ERASE_CYCLES - 32'd1;
        end else if (start_row) begin
          next_state = FEPC_ROW;
          next_timer = ROW_TMO_CYCLES - 32'd1;
        end
      end
      FEPC_MASS, FEPC_PAGE: begin
        next_timer = timer - 32'd1;
        if (timer_end) begin
          next_state = FEPC_IDLE;
          events[`FEPC_EV_MASS] = (state == FEPC_MASS);
          events[`FEPC_EV_PAGE] = (state == FEPC_PAGE);
        end
      end
      FEPC_ROW: begin
        next_timer = timer - 32'd1;
        if (row_last) begin
          next_state = FEPC_IDLE;
          events[`FEPC_EV_ROW] = 1'b1;
        end else if (row_byte) begin
          next_timer = ROW_TMO_CYCLES - 32'd1;
        end else if (timer_end) begin
          next_state = FEPC_IDLE;
          events[`FEPC_EV_TMO] = 1'b1;
        end
      end
      default: begin
        next_state = FEPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= FEPC_IDLE;
      timer <= 32'h0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ----------------------------------------
  // Address registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      info_page_select <= 1'b0;
      page_sel         <= `FEPC_PAGE_RST;
      row_sel          <= `FEPC_ROW_RST;
      col_sel          <= `FEPC_COL_RST;
    end else begin
      if (wr_page) begin
        info_page_select <= wr_req.data[`FEPC_INFO_BIT];
        page_sel         <= wr_req.data[6:0];
      end
      if (wr_row) begin
        row_sel <= wr_req.data[2:0];
      end
      if (wr_col) begin
        col_sel <= wr_req.data[6:0];
      end else if (row_byte) begin
        col_sel <= col_sel + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Flash array and stall outputs
  // ----------------------------------------
  fepc_addr_type cur_addr;
  assign cur_addr = {info_page_select,
                     info_page_select ? 7'h00 : page_sel,
                     row_sel,
                     col_sel};

  wire next_erasing = (next_state == FEPC_MASS) | (next_state == FEPC_PAGE);
  wire next_rowing  = (next_state == FEPC_ROW);
  // Only flash-targeted requests can stall; everything else passes
  wire next_wait = cpu_req & cpu_is_flash
                   & (next_erasing | (next_rowing & ~cpu_is_write));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_wait        <= 1'b0;
      arr_mass_erase  <= 1'b0;
      arr_page_erase  <= 1'b0;
      arr_row_mode    <= 1'b0;
      arr_addr        <= '0;
      arr_prog_strobe <= 1'b0;
      arr_prog_data   <= 8'h00;
    end else begin
      cpu_wait        <= next_wait;
      arr_mass_erase  <= (next_state == FEPC_MASS);
      arr_page_erase  <= (next_state == FEPC_PAGE);
      arr_row_mode    <= next_rowing;
      arr_addr        <= cur_addr;
      arr_prog_strobe <= wr_pdata;
      if (wr_pdata) begin
        arr_prog_data <= wr_req.data[7:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [`FEPC_NEV-1:0] clr_bits = (wr_lane & hit_iclr) ? wr_req.data[`FEPC_NEV-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq        <= 1'b0;
    end else begin
      // A new event beats a clear in the same cycle
      irq_status <= (irq_status & ~clr_bits) | events;
      if (wr_lane & hit_ien) begin
        irq_enable <= wr_req.data[`FEPC_NEV-1:0];
      end
      irq <= |(((irq_status & ~clr_bits) | events)
               & ((wr_lane & hit_ien) ? wr_req.data[`FEPC_NEV-1:0] : irq_enable));
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] rd_idx = rd_addr[9:2];
  wire [7:0] pgctl_val = {5'h00, state == FEPC_ROW, state == FEPC_PAGE,
                          state == FEPC_MASS};

  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    case (rd_idx)
      `FEPC_IDX_PAGE:     rd_data = {24'h0, info_page_select, page_sel};
      `FEPC_IDX_ROW:      rd_data = {29'h0, row_sel};
      `FEPC_IDX_COL:      rd_data = {25'h0, col_sel};
      `FEPC_IDX_PGCTL:    rd_data = {24'h0, pgctl_val};
      `FEPC_IDX_PDATA:    rd_data = {24'h0, arr_prog_data};
      `FEPC_IDX_IRQ_STAT: rd_data = {28'h0, irq_status};
      `FEPC_IDX_IRQ_EN:   rd_data = {28'h0, irq_enable};
      `FEPC_IDX_IRQ_CLR:  rd_data = 32'h0;
      default:            rd_err  = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  erase_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_req && cpu_is_flash && next_erasing) |=> cpu_wait)
    else $error("flash access not stalled during erase");

  other_nowait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cpu_is_flash || !cpu_req) |=> !cpu_wait)
    else $error("non-flash access stalled");

  row_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == FEPC_ROW && next_rowing && cpu_req && cpu_is_flash && !cpu_is_write)
    |=> cpu_wait && arr_row_mode)
    else $error("flash read not stalled during row program");

  info_page_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arr_addr.info |-> arr_addr.page == 7'h00)
    else $error("page field not ignored on information page");

  col_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (row_byte && !row_last) |=> col_sel == $past(col_sel) + 7'h01 && state == FEPC_ROW)
    else $error("column did not advance");

  row_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    row_last |=> state == FEPC_IDLE && col_sel == 7'h00 && irq_status[`FEPC_EV_ROW])
    else $error("row program did not end at column 128");

  mass_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_mass |=> arr_mass_erase && pgctl_val == 8'h01 ##1 arr_mass_erase)
    else $error("mass erase did not start");

  page_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == FEPC_PAGE && timer_end) |=> !arr_page_erase && pgctl_val == 8'h00
    && irq_status[`FEPC_EV_PAGE])
    else $error("page erase did not clear itself");

  row_tmo_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == FEPC_ROW && timer_end && !row_byte) |=> state == FEPC_IDLE
    && irq_status[`FEPC_EV_TMO] && !arr_row_mode)
    else $error("row timeout not taken");

  pgctl_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pgctl_val[7:3] == 5'h00 && $onehot0(pgctl_val[2:0]))
    else $error("program control reserved bits set");

  irq_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(irq_status & irq_enable))
    else $error("interrupt output disagrees with status");

  mass_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    state == FEPC_MASS && timer_end);
  page_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    start_page ##1 arr_page_erase);
  row_cov_c:  cover property (@(posedge aclk) disable iff (!aresetn) row_last);
  tmo_cov_c:  cover property (@(posedge aclk) disable iff (!aresetn)
    state == FEPC_ROW && timer_end && !row_byte);

endmodule : fepc_flash_ctrl
`default_nettype wire

// ==== tb/fepc_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module fepc_cpu_model (
  // Clock and bench command
  input  wire logic aclk,
  input  wire logic go,
  input  wire logic to_flash,
  input  wire logic is_wr,
  // CPU access lines
  output logic      cpu_req,
  output logic      cpu_is_flash,
  output logic      cpu_is_write
);
  initial begin
    cpu_req = 1'b0;
    cpu_is_flash = 1'b0;
    cpu_is_write = 1'b0;
  end

  // Idle qualifiers toggle so a stale target never looks valid
  always @(posedge aclk) begin
    cpu_req      <= go;
    cpu_is_flash <= go ? to_flash : ~cpu_is_flash;
    cpu_is_write <= go ? is_wr : ~cpu_is_write;
  end
endmodule : fepc_cpu_model

`default_nettype wire

// ==== tb/flash_erase_program_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fepc_defs.svh"

module flash_erase_program_control_tb
  import fepc_pkg::*;
();
  logic aclk = 0, aresetn = 0, go = 0, to_flash = 0, is_wr = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic cpu_req, cpu_is_flash, cpu_is_write, cpu_wait, irq;
  wire logic arr_mass_erase, arr_page_erase, arr_row_mode, arr_prog_strobe;
  wire fepc_addr_type arr_addr;
  wire logic [7:0] arr_prog_data;
  int num_errors = 0, samples_checked = 0;

  always #4 aclk = ~aclk;

  // Short counts keep erases and the row timeout within a brief run
  fepc_flash_ctrl #(.MASS_ERASE_CYCLES(40), .PAGE_ERASE_CYCLES(30), .ROW_TMO_CYCLES(20)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_is_flash, .cpu_is_write, .cpu_wait,
    .arr_mass_erase, .arr_page_erase, .arr_row_mode, .arr_addr, .arr_prog_strobe,
    .arr_prog_data, .irq);

  fepc_cpu_model i_cpu (.aclk, .go, .to_flash, .is_wr, .cpu_req, .cpu_is_flash, .cpu_is_write);

  task end_of_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
    logic a, w, done;
    a = 1;
    w = 1;
    done = 0;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // Ready stays high between transfers so back-to-back calls never drive it twice
    s_axi_bready <= 1;
    for (int n = 0; n < 99 && !done; n++) begin
      @(posedge aclk);
      if (a && s_axi_awready) begin
        a = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
      if (s_axi_bvalid) begin
        done = 1;
        chk("bresp", er, s_axi_bresp);
      end
    end
    if (!done) begin
      chk("timeout", 0, 1);
      end_of_test();
    end
  endtask : wr

  task rd(input logic [7:0] i, input logic [1:0] er);
    logic done;
    done = 0;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 99 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 0;
      end
      if (s_axi_rvalid) begin
        done = 1;
        rv = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
      end
    end
    if (!done) begin
      chk("timeout", 0, 1);
      end_of_test();
    end
  endtask : rd

  task rc(input logic [7:0] i, input logic [31:0] e);
    rd(i, `FEPC_RESP_OKAY);
    chk("rdata", e, rv);
  endtask : rc

  // Stall appears one edge after the model raises the request
  task cpu(input logic f, input logic w, input logic e);
    go <= 1;
    to_flash <= f;
    is_wr <= w;
    repeat (3) @(posedge aclk);
    chk("cpu_wait", e, cpu_wait);
    go <= 0;
    @(posedge aclk);
  endtask : cpu

  task wait_idle;
    rv = 1;
    for (int n = 0; n < 40 && rv !== 0; n++) begin
      rd(`FEPC_IDX_PGCTL, `FEPC_RESP_OKAY);
    end
    chk("pgctl_done", 0, rv);
    if (rv !== 0) begin
      end_of_test();
    end
  endtask : wait_idle

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(`FEPC_IDX_PAGE, 0);
    rc(`FEPC_IDX_ROW, 0);
    rc(`FEPC_IDX_COL, 0);
    rc(`FEPC_IDX_PGCTL, 0);
    wr(`FEPC_IDX_PAGE, 32'h85, 0);
    wr(`FEPC_IDX_ROW, 32'h1, 0);
    rc(`FEPC_IDX_PAGE, 32'h85);
    chk("info", 1, arr_addr.info);
    chk("page", 0, arr_addr.page);
    chk("info_row", 1, arr_addr.row);
    wr(`FEPC_IDX_PAGE, 32'h05, 0);
    wr(`FEPC_IDX_ROW, 32'hff, 0);
    rc(`FEPC_IDX_ROW, 32'h07);
    wr(`FEPC_IDX_COL, 32'hff, 0);
    rc(`FEPC_IDX_COL, 32'h7f);
    wr(`FEPC_IDX_PGCTL, 32'hf8, 0);
    rc(`FEPC_IDX_PGCTL, 0);
    wr(`FEPC_IDX_IRQ_EN, 32'hf, 0);
    wr(`FEPC_IDX_PGCTL, 32'h2, 0);
    rc(`FEPC_IDX_PGCTL, 32'h2);
    chk("page_erase", 1, arr_page_erase);
    chk("page", 5, arr_addr.page);
    cpu(1, 0, 1);
    cpu(0, 0, 0);
    cpu(1, 1, 1);
    wait_idle();
    rc(`FEPC_IDX_IRQ_STAT, 32'h2);
    chk("irq", 1, irq);
    wr(`FEPC_IDX_IRQ_EN, 0, 0);
    chk("irq_mask", 0, irq);
    wr(`FEPC_IDX_IRQ_CLR, 32'hf, 0);
    wr(`FEPC_IDX_IRQ_EN, 32'hf, 0);
    chk("irq_clr", 0, irq);
    wr(`FEPC_IDX_PGCTL, 32'h1, 0);
    chk("mass_erase", 1, arr_mass_erase);
    cpu(1, 1, 1);
    wait_idle();
    rc(`FEPC_IDX_IRQ_STAT, 32'h1);
    wr(`FEPC_IDX_IRQ_CLR, 32'hf, 0);
    wr(`FEPC_IDX_COL, 32'h10, 0);
    wr(`FEPC_IDX_PDATA, 32'h3c, 0);
    chk("prog_strobe", 1, arr_prog_strobe);
    chk("prog_col", 32'h10, arr_addr.col);
    chk("prog_data", 32'h3c, arr_prog_data);
    rc(`FEPC_IDX_COL, 32'h10);
    wr(`FEPC_IDX_COL, 32'h7e, 0);
    wr(`FEPC_IDX_PGCTL, 32'h4, 0);
    chk("row_mode", 1, arr_row_mode);
    cpu(1, 0, 1);
    cpu(1, 1, 0);
    wr(`FEPC_IDX_PDATA, 32'ha5, 0);
    wr(`FEPC_IDX_PDATA, 32'h5a, 0);
    rc(`FEPC_IDX_PGCTL, 0);
    chk("row_mode_end", 0, arr_row_mode);
    rc(`FEPC_IDX_IRQ_STAT, 32'h4);
    wr(`FEPC_IDX_IRQ_CLR, 32'hf, 0);
    wr(`FEPC_IDX_PGCTL, 32'h4, 0);
    wait_idle();
    rc(`FEPC_IDX_IRQ_STAT, 32'h8);
    wr(8'h20, 32'h1, `FEPC_RESP_SLVERR);
    rd(8'h20, `FEPC_RESP_SLVERR);
    chk("rdata", 0, rv);
    end_of_test();
  end
endmodule : flash_erase_program_control_tb

`default_nettype wire
